// file: src/osh_pkg.sv
package osh_pkg;

  // ==========================================================================
  // Dual-use pin positions (index 7 is the pin that also carries serial out).
  // ==========================================================================
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned PIN_FRAME_WIDTH = 0;
  localparam int unsigned PIN_WD_PRESET = 1;
  localparam int unsigned PIN_OUT_DISABLE = 2;
  localparam int unsigned PIN_WD_KICK = 3;
  localparam int unsigned PIN_SDI = 4;
  localparam int unsigned PIN_CLK = 5;
  localparam int unsigned PIN_SS = 6;
  localparam int unsigned PIN_SDO = 7;
  localparam int unsigned SYNC_WIDTH = 9;
  localparam int unsigned SYNC_SELECT = 8;

  // ==========================================================================
  // Register map and fields.
  // ==========================================================================
  localparam logic [7:0] REG_IRQ_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_MASK = 8'h04;
  localparam logic [7:0] REG_STATE = 8'h08;
  localparam logic [7:0] REG_LAST_FRAME = 8'h0c;
  localparam int unsigned EVT_COUNT = 4;
  localparam int unsigned EVT_FRAME = 0;
  localparam int unsigned EVT_OVT = 1;
  localparam int unsigned EVT_CASE = 2;
  localparam int unsigned EVT_UV = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [15:0] FRAME_RESET = 16'h0000;

  // ==========================================================================
  // Status byte of the long fault frame.
  // ==========================================================================
  localparam int unsigned STAT_PG = 7;
  localparam int unsigned STAT_CASE = 6;

  typedef enum logic {LINK_IDLE, LINK_SHIFT} osh_link_t;

endpackage : osh_pkg

// file: src/osh_sync_if.sv
`timescale 1ns/10ps
interface osh_sync_if #(
  parameter int unsigned W = 9
);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  modport producer (input raw, output level, output rise, output fall);
  modport consumer (output raw, input level, input rise, input fall);
endinterface : osh_sync_if

// file: src/osh_pin_sync.sv
`timescale 1ns/10ps
module osh_pin_sync (
  input wire logic clk,
  input wire logic resetn,
  osh_sync_if.producer sp
);
  localparam int unsigned W = osh_pkg::SYNC_WIDTH;

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] level;

  // ==========================================================================
  // Three-flop chain; a change is accepted once stages two and three agree.
  // ==========================================================================
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end
    else
    begin
      stage1 <= sp.raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          level[i] <= 1'b0;
        else if (stage2[i] == stage3[i])
          level[i] <= stage3[i];
      end
      // Pulses lead the level by one cycle so the consumer sees them in the cycle the change is accepted.
      assign sp.rise[i] = stage2[i] & stage3[i] & ~level[i];
      assign sp.fall[i] = ~stage2[i] & ~stage3[i] & level[i];
    end
  endgenerate

  assign sp.level = level;

endmodule : osh_pin_sync

// file: src/osh_top.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module osh_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic interface_select,
  input wire logic [7:0] dual_pin_in,
  output logic sdo_out,
  output logic sdo_oe,
  input wire logic [7:0] junction_hot,
  input wire logic case_hot,
  input wire logic undervoltage,
  input wire logic supply_good,
  output logic [7:0] out_on,
  output logic fault_n_oe,
  output logic case_heat_warning_n_oe,
  output logic supply_good_n_oe,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);

  // ==========================================================================
  // Pin synchronisers.
  // ==========================================================================
  osh_sync_if #(.W(osh_pkg::SYNC_WIDTH)) sync_bus ();

  assign sync_bus.raw = {interface_select, dual_pin_in};

  osh_pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .sp(sync_bus.producer)
  );

  logic serial_mode;
  logic [7:0] pin_level;
  logic frame_long;
  logic output_disable_n;
  logic ss_fall;
  logic ss_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic sdi_level;

  // The synchroniser resets to zero, so an undriven strap reads as parallel mode.
  assign serial_mode = sync_bus.level[osh_pkg::SYNC_SELECT];
  assign pin_level = sync_bus.level[7:0];
  assign frame_long = pin_level[osh_pkg::PIN_FRAME_WIDTH];
  assign output_disable_n = pin_level[osh_pkg::PIN_OUT_DISABLE];
  assign ss_fall = serial_mode & sync_bus.fall[osh_pkg::PIN_SS];
  assign ss_rise = serial_mode & sync_bus.rise[osh_pkg::PIN_SS];
  assign sclk_rise = sync_bus.rise[osh_pkg::PIN_CLK];
  assign sclk_fall = sync_bus.fall[osh_pkg::PIN_CLK];
  assign sdi_level = sync_bus.level[osh_pkg::PIN_SDI];

  // ==========================================================================
  // Link state.
  // ==========================================================================
  osh_pkg::osh_link_t link_state;
  osh_pkg::osh_link_t next_link_state;

  always_comb
  begin
    next_link_state = link_state;
    case (link_state)
      osh_pkg::LINK_IDLE:
        if (ss_fall)
          next_link_state = osh_pkg::LINK_SHIFT;
      osh_pkg::LINK_SHIFT:
        if (ss_rise || !serial_mode)
          next_link_state = osh_pkg::LINK_IDLE;
      default:
        next_link_state = osh_pkg::LINK_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      link_state <= osh_pkg::LINK_IDLE;
    else
      link_state <= next_link_state;
  end

  // ==========================================================================
  // Fault latches.
  // ==========================================================================
  logic [7:0] fault_latch;
  logic [7:0] fault_now;
  logic pg_bit;

  assign fault_now = fault_latch | junction_hot;

  // A fault that coincides with the clearing frame edge stays latched.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      fault_latch <= 8'h00;
    else if (ss_rise)
      fault_latch <= junction_hot;
    else
      fault_latch <= fault_now;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pg_bit <= 1'b0;
    else if (supply_good)
      pg_bit <= 1'b1;
    else if (ss_rise)
      pg_bit <= 1'b0;
  end

  // ==========================================================================
  // Shift registers.
  // ==========================================================================
  logic [15:0] rx_shift;
  logic [15:0] tx_shift;
  logic [15:0] fault_frame;

  always_comb
  begin
    fault_frame = {fault_now, 8'h00};
    if (frame_long)
    begin
      fault_frame[osh_pkg::STAT_PG] = pg_bit;
      fault_frame[osh_pkg::STAT_CASE] = case_hot;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rx_shift <= osh_pkg::FRAME_RESET;
    else if (link_state == osh_pkg::LINK_SHIFT && sclk_rise)
      rx_shift <= {rx_shift[14:0], sdi_level};
  end

  // Incoming bits follow the fault bits out, which keeps a daisy chain intact.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tx_shift <= osh_pkg::FRAME_RESET;
    else if (ss_fall)
      tx_shift <= frame_long ? fault_frame : {fault_frame[15:8], 8'h00};
    else if (link_state == osh_pkg::LINK_SHIFT && sclk_fall)
      tx_shift <= frame_long ? {tx_shift[14:0], rx_shift[0]} : {tx_shift[14:8], rx_shift[0], 8'h00};
  end

  assign sdo_out = tx_shift[15];
  assign sdo_oe = link_state == osh_pkg::LINK_SHIFT;

  // ==========================================================================
  // Channel commands and outputs.
  // ==========================================================================
  logic [7:0] cmd;
  logic [7:0] cmd_src;
  logic [15:0] last_frame;

  // Pulling the disable pin low drops the command, so the host must send a new frame.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cmd <= osh_pkg::CMD_RESET;
    else if (!serial_mode || !output_disable_n)
      cmd <= osh_pkg::CMD_RESET;
    else if (ss_rise)
      cmd <= frame_long ? rx_shift[15:8] : rx_shift[7:0];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      last_frame <= osh_pkg::FRAME_RESET;
    else if (ss_rise)
      last_frame <= rx_shift;
  end

  assign cmd_src = serial_mode ? cmd : pin_level;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_on <= 8'h00;
      fault_n_oe <= 1'b0;
      case_heat_warning_n_oe <= 1'b0;
      supply_good_n_oe <= 1'b0;
    end
    else
    begin
      out_on <= cmd_src & ~junction_hot & {8{~case_hot & ~undervoltage}};
      fault_n_oe <= |(junction_hot & cmd_src);
      case_heat_warning_n_oe <= case_hot;
      supply_good_n_oe <= supply_good;
    end
  end

  // ==========================================================================
  // Interrupt status and register port.
  // ==========================================================================
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] event_now;
  logic case_prev;
  logic uv_prev;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      case_prev <= 1'b0;
      uv_prev <= 1'b0;
    end
    else
    begin
      case_prev <= case_hot;
      uv_prev <= undervoltage;
    end
  end

  always_comb
  begin
    event_now = 4'h0;
    event_now[osh_pkg::EVT_FRAME] = ss_rise;
    event_now[osh_pkg::EVT_OVT] = |(junction_hot & ~fault_latch);
    event_now[osh_pkg::EVT_CASE] = case_hot & ~case_prev;
    event_now[osh_pkg::EVT_UV] = undervoltage & ~uv_prev;
  end

  // Setting wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_status <= 4'h0;
    else if (reg_wr && reg_addr == osh_pkg::REG_IRQ_STATUS)
      irq_status <= (irq_status & ~reg_wdata[3:0]) | event_now;
    else
      irq_status <= irq_status | event_now;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask <= osh_pkg::IRQ_MASK_RESET;
    else if (reg_wr && reg_addr == osh_pkg::REG_IRQ_MASK)
      irq_mask <= reg_wdata[3:0];
  end

  assign irq = |(irq_status & irq_mask);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      case (reg_addr)
        osh_pkg::REG_IRQ_STATUS: reg_rdata <= {28'h0000000, irq_status};
        osh_pkg::REG_IRQ_MASK: reg_rdata <= {28'h0000000, irq_mask};
        osh_pkg::REG_STATE: reg_rdata <= {12'h000, pg_bit, frame_long, serial_mode, sdo_oe, fault_latch, out_on};
        osh_pkg::REG_LAST_FRAME: reg_rdata <= {16'h0000, last_frame};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ==========================================================================
  // Checks.
  // ==========================================================================
  logic link_active;
  assign link_active = link_state == osh_pkg::LINK_SHIFT;

  chk_sdo_float: assert property (@(posedge clk) disable iff (!resetn)
    (serial_mode && sync_bus.level[osh_pkg::PIN_SS]) |-> !sdo_oe)
    else $error("SDO driven while not selected");

  chk_sdo_first_bit: assert property (@(posedge clk) disable iff (!resetn)
    ss_fall |=> sdo_oe && sdo_out == $past(fault_now[7]))
    else $error("SDO does not show fault MSB after select");

  chk_sdi_sample: assert property (@(posedge clk) disable iff (!resetn)
    (link_active && sclk_rise) |=> rx_shift[0] == $past(sdi_level))
    else $error("SDI not sampled on rising clock");

  chk_sdo_shift: assert property (@(posedge clk) disable iff (!resetn)
    (link_active && sclk_fall && !ss_fall) |=> sdo_out == $past(tx_shift[14]))
    else $error("SDO did not advance on falling clock");

  chk_frame_apply: assert property (@(posedge clk) disable iff (!resetn)
    (ss_rise && !frame_long && output_disable_n) |=> cmd == $past(rx_shift[7:0]))
    else $error("Short frame not applied on deselect");

  chk_parallel_follow: assert property (@(posedge clk) disable iff (!resetn)
    (!serial_mode && !undervoltage && !case_hot && junction_hot == 8'h00) |=> out_on == $past(pin_level))
    else $error("Parallel outputs do not follow pins");

  chk_uv_off: assert property (@(posedge clk) disable iff (!resetn)
    undervoltage |=> out_on == 8'h00)
    else $error("Output on during undervoltage");

  chk_ovt_off: assert property (@(posedge clk) disable iff (!resetn)
    junction_hot != 8'h00 |=> (out_on & $past(junction_hot)) == 8'h00 && (fault_latch & $past(junction_hot)) != 8'h00)
    else $error("Hot channel still on or unflagged");

  chk_pg_hold: assert property (@(posedge clk) disable iff (!resetn)
    supply_good |=> pg_bit)
    else $error("Power-good bit not held");

  chk_serial_mode: assert property (@(posedge clk) disable iff (!resetn)
    !serial_mode |=> cmd == 8'h00 && !$past(ss_rise))
    else $error("Serial command kept in parallel mode");

  cov_short_frame: cover property (@(posedge clk) disable iff (!resetn)
    ss_rise && !frame_long);
  cov_long_frame: cover property (@(posedge clk) disable iff (!resetn)
    ss_rise && frame_long);
  cov_overheat: cover property (@(posedge clk) disable iff (!resetn)
    event_now[osh_pkg::EVT_OVT]);
  cov_irq: cover property (@(posedge clk) disable iff (!resetn)
    $rose(irq));

endmodule : osh_top

// file: verif/osh_host_model.sv
`timescale 1ns/10ps
module osh_host_model (
  input wire logic clk,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  output logic ss_n,
  output logic sck,
  output logic sdi,
  output logic sdo_seen
);
  logic sdo_hold = 1'b0;

  initial
  begin
    ss_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end

  always @(posedge clk)
  begin
    if (sdo_oe)
      sdo_hold <= sdo_out;
  end

  // A released line shows the inverse of its last bit, so a stale bit never passes for a good one.
  assign sdo_seen = sdo_oe ? sdo_out : ~sdo_hold;

  // ==========================================================================
  // One frame of n bits, most significant first, half period in ns.
  // ==========================================================================
  task automatic xfer(input logic [15:0] tx, input int n, input int half, output logic [15:0] rx);
    rx = 16'h0000;
    // Starting off the falling edge keeps every pin change clear of a rising clock edge.
    @(negedge clk);
    #1;
    ss_n = 1'b0;
    sdi = tx[n-1];
    #(half);
    for (int i = n - 1; i >= 0; i--)
    begin
      sck = 1'b1;
      rx = {rx[14:0], sdo_seen};
      #(half);
      sck = 1'b0;
      if (i > 0)
        sdi = tx[i-1];
      #(half);
    end
    ss_n = 1'b1;
    #(4 * half);
  endtask : xfer
endmodule : osh_host_model

// file: verif/osh_top_test.sv
`timescale 1ns/10ps
module osh_top_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic interface_select = 1'b0;
  logic [7:0] par_pins = 8'h00;
  logic fw = 1'b0;
  logic oen = 1'b1;
  logic [7:0] junction_hot = 8'h00;
  logic case_hot = 1'b0;
  logic undervoltage = 1'b0;
  logic supply_good = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq, sdo_out, sdo_oe, fault_n_oe, case_heat_warning_n_oe, supply_good_n_oe;
  logic ss_n, sck, sdi, sdo_seen;
  logic [7:0] out_on;
  logic [7:0] dual_pin;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] rx;
  logic [31:0] rd;

  always #2.5 clk = ~clk;

  assign dual_pin = interface_select ? {sdo_seen, ss_n, sck, sdi, 1'b1, oen, 1'b0, fw} : par_pins;

  osh_top dut (.clk(clk), .resetn(resetn), .interface_select(interface_select), .dual_pin_in(dual_pin),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .junction_hot(junction_hot), .case_hot(case_hot),
    .undervoltage(undervoltage), .supply_good(supply_good), .out_on(out_on), .fault_n_oe(fault_n_oe),
    .case_heat_warning_n_oe(case_heat_warning_n_oe), .supply_good_n_oe(supply_good_n_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq));

  osh_host_model host (.clk(clk), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .ss_n(ss_n), .sck(sck), .sdi(sdi),
    .sdo_seen(sdo_seen));

  // ==========================================================================
  // Shared tasks.
  // ==========================================================================
  task automatic end_of_test();
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cycles

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  task automatic test_reset();
    check(out_on, 8'h00, "out after reset");
    check(sdo_oe, 1'b0, "sdo float after reset");
    reg_read(osh_pkg::REG_IRQ_MASK, rd);
    check(rd[3:0], osh_pkg::IRQ_MASK_RESET, "mask reset");
    reg_write(8'h10, 32'hffff_ffff);
    reg_read(8'h10, rd);
    check(rd, 32'h0, "unmapped read");
  endtask : test_reset

  task automatic test_parallel();
    par_pins <= 8'ha5;
    cycles(8);
    check(out_on, 8'ha5, "parallel inputs");
    par_pins <= 8'h80;
    cycles(8);
    check(out_on, 8'h80, "pin eight is channel eight");
  endtask : test_parallel

  task automatic test_frame8();
    interface_select <= 1'b1;
    cycles(8);
    check(sdo_oe, 1'b0, "sdo float idle");
    junction_hot <= 8'h40;
    cycles(2);
    junction_hot <= 8'h00;
    host.xfer(16'h0081, 8, 32, rx);
    check(rx[7:0], 8'h40, "fault frame");
    cycles(8);
    check(out_on, 8'h81, "short frame outputs");
    check(sdo_oe, 1'b0, "sdo float after frame");
    host.xfer(16'h007e, 8, 32, rx);
    check(rx[7:0], 8'h00, "faults cleared");
    cycles(8);
    check(out_on, 8'h7e, "second frame outputs");
    host.xfer(16'h5a0f, 16, 32, rx);
    check(rx, 16'h005a, "extra bits follow faults");
    cycles(8);
    check(out_on, 8'h0f, "last eight bits");
    reg_read(osh_pkg::REG_LAST_FRAME, rd);
    check(rd, 32'h0000_5a0f, "last frame register");
  endtask : test_frame8

  task automatic test_frame16();
    fw <= 1'b1;
    supply_good <= 1'b1;
    cycles(8);
    check(supply_good_n_oe, 1'b1, "power good pin");
    host.xfer(16'h3c00, 16, 32, rx);
    check(rx, 16'h0080, "long fault frame");
    cycles(8);
    check(out_on, 8'h3c, "long frame outputs");
    supply_good <= 1'b0;
    case_hot <= 1'b1;
    cycles(8);
    check(out_on, 8'h00, "case heat off");
    check(case_heat_warning_n_oe, 1'b1, "case warning pin");
    host.xfer(16'h3c00, 16, 32, rx);
    check(rx, 16'h00c0, "power good held");
    case_hot <= 1'b0;
    cycles(8);
    host.xfer(16'h3c00, 16, 32, rx);
    check(rx, 16'h0000, "power good cleared");
    fw <= 1'b0;
  endtask : test_frame16

  task automatic test_protect();
    host.xfer(16'h00ff, 8, 32, rx);
    cycles(8);
    junction_hot <= 8'h01;
    cycles(4);
    check(out_on, 8'hfe, "hot channel off");
    check(fault_n_oe, 1'b1, "fault pin active");
    junction_hot <= 8'h00;
    cycles(4);
    check(fault_n_oe, 1'b0, "fault pin released");
    undervoltage <= 1'b1;
    cycles(4);
    check(out_on, 8'h00, "undervoltage off");
    undervoltage <= 1'b0;
    host.xfer(16'h0033, 8, 32, rx);
    cycles(8);
    check(out_on, 8'h33, "normal again");
    reg_read(osh_pkg::REG_STATE, rd);
    check(rd, 32'h0002_0033, "state register");
    oen <= 1'b0;
    cycles(8);
    check(out_on, 8'h00, "disable pin");
    oen <= 1'b1;
    cycles(8);
    check(out_on, 8'h00, "needs resend");
  endtask : test_protect

  task automatic test_irq();
    reg_write(osh_pkg::REG_IRQ_STATUS, 32'hf);
    host.xfer(16'h0001, 8, 32, rx);
    junction_hot <= 8'h04;
    cycles(2);
    junction_hot <= 8'h00;
    reg_read(osh_pkg::REG_IRQ_STATUS, rd);
    check(rd[3:0], 4'h3, "events sticky");
    check(irq, 1'b0, "masked irq");
    reg_write(osh_pkg::REG_IRQ_MASK, 32'h1);
    cycles(1);
    check(irq, 1'b1, "unmasked irq");
    reg_write(osh_pkg::REG_IRQ_STATUS, 32'h1);
    cycles(1);
    check(irq, 1'b0, "cleared irq");
    reg_read(osh_pkg::REG_IRQ_STATUS, rd);
    check(rd[3:0], 4'h2, "one bit cleared");
  endtask : test_irq

  // ==========================================================================
  // Sequence and hang guard.
  // ==========================================================================
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    cycles(2);
    test_reset();
    test_parallel();
    test_frame8();
    test_frame16();
    test_protect();
    test_irq();
    end_of_test();
  end
endmodule : osh_top_test
